// >>> hdl/sched_pkg.sv
package sched_pkg;
	// ---------------------------------------------------------------
	// block codes seen in output image word 0
	// ---------------------------------------------------------------
	localparam logic [15:0] data_code_max = 16'h029a;
	localparam logic [15:0] queue_code_base = 16'h07d0;
	localparam logic [15:0] queue_code_min = 16'h07d1;
	localparam logic [15:0] queue_code_max = 16'h07d6;
	localparam logic [15:0] warm_start_code = 16'h270e;
	localparam logic [15:0] restart_code = 16'h270f;
	// ---------------------------------------------------------------
	// image layout and list sizes
	// ---------------------------------------------------------------
	localparam int image_words = 7;
	localparam int queued_count_word = 2;
	localparam int cmd_list_max = 100;
	localparam int cmd_index_width = 7;
	localparam int queue_depth = 8;
	localparam int status_words = 32;
	localparam logic [15:0] status_addr_off = 16'hffff;
	localparam logic [15:0] status_freq_off = 16'h0000;
	// ---------------------------------------------------------------
	// status block word offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] program_cycle_counter = 5'h00;
	localparam logic [4:0] last_read_block_code = 5'h01;
	localparam logic [4:0] current_read_block_code = 5'h02;
	localparam logic [4:0] current_write_block_code = 5'h03;
	localparam logic [4:0] current_command_index = 5'h04;
	localparam logic [4:0] total_command_count = 5'h05;
	localparam logic [4:0] queued_command_count = 5'h06;
	localparam logic [4:0] master_port_state = 5'h07;
	localparam logic [4:0] master_port_comm_state = 5'h08;
	localparam logic [4:0] product_name_text = 5'h09;
	localparam logic [4:0] firmware_revision_text = 5'h0b;
	localparam logic [4:0] os_revision_text = 5'h0d;
	localparam logic [4:0] production_run_text = 5'h0f;
	localparam logic [4:0] command_request_count = 5'h11;
	localparam logic [4:0] command_response_count = 5'h12;
	localparam logic [4:0] command_error_count = 5'h13;
	localparam logic [4:0] request_count = 5'h14;
	localparam logic [4:0] response_count = 5'h15;
	localparam logic [4:0] errors_received_count = 5'h16;
	localparam logic [4:0] errors_sent_count = 5'h17;
	localparam logic [4:0] reserved_word_a = 5'h18;
	localparam logic [4:0] reserved_word_b = 5'h19;
	localparam logic [4:0] read_block_op_count = 5'h1a;
	localparam logic [4:0] write_block_op_count = 5'h1b;
	localparam logic [4:0] blocks_parsed_count = 5'h1c;
	localparam logic [4:0] event_blocks_count = 5'h1d;
	localparam logic [4:0] command_blocks_count = 5'h1e;
	localparam logic [4:0] transfer_error_count = 5'h1f;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int clk_mhz = 125;
	localparam int second_us = 1000000;
	localparam int second_cycles = second_us * clk_mhz;
	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [cmd_index_width-1:0] index;
		logic [15:0] data;
		logic write;
	} issue_type;
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} db_write_type;
	typedef enum logic [1:0] {
		st_idle,
		st_issue,
		st_delay
	} sched_state_type;
endpackage : sched_pkg

// >>> hdl/block_transfer_command_scheduler.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// small fifo between the queue block decoder and the scheduler
// ---------------------------------------------------------------
module cmd_fifo #(
	parameter int width = 7,
	parameter int depth = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [width-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [width-1:0] out_data_o,
	input wire logic flush_i,
	output logic [$clog2(depth):0] level_o
);
	localparam int aw = $clog2(depth);
	typedef struct packed {
		logic [depth-1:0][width-1:0] mem;
		logic [aw-1:0] rd;
		logic [aw-1:0] wr;
		logic [aw:0] cnt;
	} fifo_state_type;
	fifo_state_type s_ff, nxt_s;
	logic push, pop;
	assign in_ready_o = (s_ff.cnt != (aw+1)'(depth));
	assign out_valid_o = (s_ff.cnt != '0);
	assign out_data_o = s_ff.mem[s_ff.rd];
	assign level_o = s_ff.cnt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// pointers wrap by power-of-two depth
	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wr] = in_data_i;
			nxt_s.wr = s_ff.wr + 1'b1;
		end
		if (pop)
			nxt_s.rd = s_ff.rd + 1'b1;
		nxt_s.cnt = s_ff.cnt + (aw+1)'(push) - (aw+1)'(pop);
		if (flush_i) begin
			nxt_s.rd = '0;
			nxt_s.wr = '0;
			nxt_s.cnt = '0;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
endmodule : cmd_fifo

// ---------------------------------------------------------------
// scheduler top
// ---------------------------------------------------------------
module block_transfer_command_scheduler
	import sched_pkg::*;
#(
	parameter int sec_cycles = second_cycles,
	parameter logic [31:0] product_id = 32'h41424344, // arbitrary value
	parameter logic [31:0] fw_rev = 32'h30313030, // arbitrary value
	parameter logic [31:0] os_rev = 32'h30313030, // arbitrary value
	parameter logic [31:0] run_no = 32'h30303031 // arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] out_word0_i,
	input wire logic [15:0] out_word_i [1:6],
	input wire logic [15:0] status_addr_i,
	input wire logic [15:0] status_freq_i,
	input wire logic [15:0] cmd_delay_i,
	input wire logic [6:0] cmd_count_i,
	input wire logic [cmd_index_width-1:0] cfg_index_i,
	input wire logic cfg_we_i,
	input wire logic [15:0] cfg_poll_i,
	input wire logic [1:0] cfg_enable_i,
	input wire logic cfg_write_i,
	input wire logic [15:0] cfg_data_i,
	input wire logic issue_done_i,
	output logic [15:0] in_word0_o,
	output logic [15:0] in_word2_o,
	output logic issue_valid_o,
	output issue_type issue_o,
	output db_write_type db_o,
	output logic reload_o,
	output logic restart_o
);
	localparam int n = cmd_list_max;
	typedef struct packed {
		logic [15:0] last_code;
		logic [15:0] reply0;
		logic [15:0] reply2;
		logic [31:0] sec_cnt;
		logic [n-1:0][16:0] poll_left;
		logic [n-1:0][15:0] poll;
		logic [n-1:0][1:0] en;
		logic [n-1:0] wr;
		logic [n-1:0][15:0] data;
		logic [n-1:0][15:0] sent;
		logic [cmd_index_width-1:0] idx;
		logic [16:0] dly;
		sched_state_type st;
		logic issue_valid;
		issue_type issue;
		logic [status_words-1:0][15:0] stat;
		logic [15:0] upd;
		logic [4:0] wptr;
		db_write_type db;
		logic reload;
		logic restart;
	} top_state_type;
	top_state_type s_ff, nxt_s;
	logic [15:0] code_s1_ff, code_s2_ff;
	logic q_in_ready, q_out_valid, q_pop, q_flush;
	logic [cmd_index_width-1:0] q_out_data;
	logic [$clog2(queue_depth):0] q_level;
	logic [2:0] q_push_cnt;
	// code word crosses from the backplane: two stages before use
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			code_s1_ff <= '0;
			code_s2_ff <= '0;
		end else begin
			code_s1_ff <= out_word0_i;
			code_s2_ff <= code_s1_ff;
		end
	end
	logic new_code, is_queue, is_warm, is_cold;
	logic [2:0] want;
	assign new_code = (code_s2_ff != s_ff.last_code);
	assign is_queue = new_code && code_s2_ff >= queue_code_min && code_s2_ff <= queue_code_max;
	assign is_warm = new_code && code_s2_ff == warm_start_code;
	assign is_cold = new_code && code_s2_ff == restart_code;
	assign want = 3'(code_s2_ff - queue_code_base);
	// free fifo room caps the batch; the surplus indexes are dropped
	always_comb begin
		q_push_cnt = '0;
		if (is_queue) begin
			q_push_cnt = (q_level + 4'(want) > 4'(queue_depth)) ?
				3'(4'(queue_depth) - q_level) : want;
		end
	end
	assign q_flush = is_warm || is_cold;
	// queued indexes live in the fifo; held here as a batch loader
	logic [2:0] load_left_ff, nxt_load_left;
	logic [15:0] load_words_ff [1:6];
	logic [2:0] load_pos_ff, nxt_load_pos;
	logic ld_valid;
	assign ld_valid = load_left_ff != '0;
	cmd_fifo #(.width(cmd_index_width), .depth(queue_depth)) u_q (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(ld_valid),
		.in_ready_o(q_in_ready),
		.in_data_i(load_words_ff[load_pos_ff][cmd_index_width-1:0]),
		.out_valid_o(q_out_valid),
		.out_ready_i(q_pop),
		.out_data_o(q_out_data),
		.flush_i(q_flush),
		.level_o(q_level)
	);
	// batch loader walks the block words into the fifo
	always_comb begin
		nxt_load_left = load_left_ff;
		nxt_load_pos = load_pos_ff;
		if (q_flush) begin
			nxt_load_left = '0;
		end else if (is_queue) begin
			nxt_load_left = q_push_cnt;
			nxt_load_pos = 3'h1;
		end else if (ld_valid && q_in_ready) begin
			nxt_load_left = load_left_ff - 3'h1;
			nxt_load_pos = load_pos_ff + 3'h1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			load_left_ff <= '0;
			load_pos_ff <= 3'h1;
			for (int i = 1; i <= 6; i++)
				load_words_ff[i] <= '0;
		end else begin
			load_left_ff <= nxt_load_left;
			load_pos_ff <= nxt_load_pos;
			if (is_queue)
				for (int i = 1; i <= 6; i++)
					load_words_ff[i] <= out_word_i[i];
		end
	end
	logic tick, cand_ok, cand_skip;
	logic [cmd_index_width-1:0] cand;
	logic cand_forced;
	assign tick = (s_ff.sec_cnt == 32'(sec_cycles - 1));
	assign cand_forced = q_out_valid;
	assign cand = cand_forced ? q_out_data : s_ff.idx;
	assign cand_ok = cand_forced || (s_ff.en[cand] != 2'h0 && s_ff.poll_left[cand] == '0);
	assign cand_skip = s_ff.wr[cand] && s_ff.en[cand] == 2'h2 && !cand_forced &&
		s_ff.data[cand] == s_ff.sent[cand];
	assign q_pop = (s_ff.st == st_idle) && q_out_valid && !q_flush;
	// main loop: decode, schedule, keep status
	always_comb begin
		nxt_s = s_ff;
		nxt_s.db.valid = 1'b0;
		nxt_s.reload = 1'b0;
		nxt_s.restart = 1'b0;
		nxt_s.sec_cnt = tick ? '0 : s_ff.sec_cnt + 32'h1;
		nxt_s.stat[program_cycle_counter] = s_ff.stat[program_cycle_counter] + 16'h1;
		for (int i = 0; i < n; i++)
			if (tick && s_ff.poll_left[i] != '0)
				nxt_s.poll_left[i] = s_ff.poll_left[i] - 17'h1;
		if (cfg_we_i && 32'(cfg_index_i) < n) begin
			nxt_s.poll[cfg_index_i] = cfg_poll_i;
			nxt_s.en[cfg_index_i] = cfg_enable_i;
			nxt_s.wr[cfg_index_i] = cfg_write_i;
			nxt_s.data[cfg_index_i] = cfg_data_i;
		end
		if (new_code) begin
			nxt_s.last_code = code_s2_ff;
			nxt_s.stat[blocks_parsed_count] = s_ff.stat[blocks_parsed_count] + 16'h1;
			if (code_s2_ff != '0 && code_s2_ff <= data_code_max) begin
				nxt_s.stat[read_block_op_count] = s_ff.stat[read_block_op_count] + 16'h1;
				nxt_s.stat[last_read_block_code] = code_s2_ff;
			end else if (!is_queue && !is_warm && !is_cold)
				nxt_s.stat[transfer_error_count] = s_ff.stat[transfer_error_count] + 16'h1;
		end
		if (is_queue) begin
			nxt_s.reply0 = code_s2_ff;
			nxt_s.reply2 = 16'(q_push_cnt);
			nxt_s.stat[command_blocks_count] = s_ff.stat[command_blocks_count] + 16'h1;
		end
		// scheduler
		case (s_ff.st)
			st_idle: begin
				if (cmd_count_i != '0 || cand_forced) begin
					if (cand_ok && !cand_skip) begin
						nxt_s.issue.index = cand;
						nxt_s.issue.data = s_ff.data[cand];
						nxt_s.issue.write = s_ff.wr[cand];
						nxt_s.issue_valid = 1'b1;
						nxt_s.sent[cand] = s_ff.data[cand];
						nxt_s.poll_left[cand] = (s_ff.poll[cand] == '0) ? '0 : 17'(s_ff.poll[cand]) + 17'h1;
						nxt_s.stat[command_request_count] = s_ff.stat[command_request_count] + 16'h1;
						nxt_s.stat[current_command_index] = 16'(cand);
						nxt_s.st = st_issue;
					end
					if (!cand_forced)
						nxt_s.idx = (32'(s_ff.idx) + 1 >= 32'(cmd_count_i) || 32'(s_ff.idx) + 1 >= n) ?
							'0 : s_ff.idx + 1'b1;
				end
			end
			st_issue: begin
				if (issue_done_i) begin
					nxt_s.issue_valid = 1'b0;
					nxt_s.dly = 17'(cmd_delay_i) + 17'h1; // extra tick: the first may land at once
					nxt_s.stat[command_response_count] = s_ff.stat[command_response_count] + 16'h1;
					nxt_s.st = (cmd_delay_i == '0) ? st_idle : st_delay;
				end
			end
			st_delay: begin
				if (tick) begin
					nxt_s.dly = s_ff.dly - 17'h1;
					if (s_ff.dly <= 17'h1)
						nxt_s.st = st_idle;
				end
			end
			default: nxt_s.st = st_idle;
		endcase
		nxt_s.stat[total_command_count] = 16'(cmd_count_i);
		nxt_s.stat[queued_command_count] = 16'(q_level);
		nxt_s.stat[master_port_state] = 16'(s_ff.st);
		nxt_s.stat[master_port_comm_state] = 16'(s_ff.issue_valid);
		nxt_s.stat[product_name_text] = product_id[31:16];
		nxt_s.stat[product_name_text+5'h1] = product_id[15:0];
		nxt_s.stat[firmware_revision_text] = fw_rev[31:16];
		nxt_s.stat[firmware_revision_text+5'h1] = fw_rev[15:0];
		nxt_s.stat[os_revision_text] = os_rev[31:16];
		nxt_s.stat[os_revision_text+5'h1] = os_rev[15:0];
		nxt_s.stat[production_run_text] = run_no[31:16];
		nxt_s.stat[production_run_text+5'h1] = run_no[15:0];
		nxt_s.stat[reserved_word_a] = '0;
		nxt_s.stat[reserved_word_b] = '0;
		// status refresh: one word per cycle, 32 words from the base
		if (status_addr_i != status_addr_off && status_freq_i != status_freq_off) begin
			if (s_ff.wptr != '0 || s_ff.upd == '0) begin
				nxt_s.db.valid = 1'b1;
				nxt_s.db.addr = status_addr_i + 16'(s_ff.wptr);
				nxt_s.db.data = s_ff.stat[s_ff.wptr];
				nxt_s.wptr = s_ff.wptr + 5'h1;
				if (s_ff.wptr == '0)
					nxt_s.upd = status_freq_i;
			end
			if (s_ff.upd != '0)
				nxt_s.upd = s_ff.upd - 16'h1;
		end
		// warm start and restart: no reply, state zeroed, polling from start
		if (is_warm || is_cold) begin
			nxt_s = '0;
			nxt_s.last_code = code_s2_ff;
			nxt_s.reload = is_warm;
			nxt_s.restart = is_cold;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
	assign in_word0_o = s_ff.reply0;
	assign in_word2_o = s_ff.reply2;
	assign issue_valid_o = s_ff.issue_valid;
	assign issue_o = s_ff.issue;
	assign db_o = s_ff.db;
	assign reload_o = s_ff.reload;
	assign restart_o = s_ff.restart;
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	reply_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_queue |=> in_word2_o == 16'($past(q_push_cnt))) else $error("queued count wrong");
	warm_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_warm |=> reload_o && !restart_o && db_o.valid == 1'b0) else $error("warm start missed");
	restart_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		is_cold |=> restart_o && !reload_o) else $error("restart missed");
	no_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(is_warm || is_cold) |=> in_word0_o == '0 && !issue_valid_o) else $error("ack after boot");
	status_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(status_addr_i == status_addr_off || status_freq_i == status_freq_off) ##1
		(status_addr_i == status_addr_off || status_freq_i == status_freq_off) |-> !db_o.valid)
		else $error("status written while disabled");
	status_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		db_o.valid |-> (db_o.addr - $past(status_addr_i)) < 16'(status_words)) else $error("status out of range");
	cycle_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!is_warm && !is_cold |=> s_ff.stat[program_cycle_counter] == $past(s_ff.stat[program_cycle_counter]) + 16'h1)
		else $error("cycle counter stuck");
	poll_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(issue_valid_o) && !$past(cand_forced) |-> $past(s_ff.poll_left[cand]) == '0)
		else $error("poll interval ignored");
	issue_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(issue_valid_o));
	queue_c: cover property (@(posedge clk_i) disable iff (rst_i) is_queue);
	warm_c: cover property (@(posedge clk_i) disable iff (rst_i) is_warm);
	status_c: cover property (@(posedge clk_i) disable iff (rst_i) db_o.valid && s_ff.wptr == 5'h1f);
endmodule : block_transfer_command_scheduler

// >>> tb/port_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// far side command port model
// ---------------------------------------------------------------
module port_model
	import sched_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic issue_valid_i,
	input wire issue_type issue_i,
	input wire logic [7:0] latency_i,
	output logic done_o
);
	int log_idx[$];
	int log_dat[$];
	int log_cyc[$];
	int cyc;
	int wait_cnt;
	bit busy;
	bit sent;
	// take one command, answer after the latency, then wait for valid to drop
	// so a long valid is never logged twice
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
			busy = 0;
			sent = 0;
			cyc = 0;
			log_idx.delete();
			log_dat.delete();
			log_cyc.delete();
		end else begin
			cyc++;
			done_o <= 1'b0;
			if (issue_valid_i && !busy) begin
				busy = 1;
				wait_cnt = latency_i;
				log_idx.push_back(issue_i.index);
				log_dat.push_back(issue_i.data);
				log_cyc.push_back(cyc);
			end else if (busy && wait_cnt != 0) begin
				wait_cnt--;
			end else if (busy && !sent) begin
				done_o <= 1'b1;
				sent = 1;
			end else if (sent && !issue_valid_i) begin
				busy = 0;
				sent = 0;
			end
		end
	end
endmodule : port_model

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
	import sched_pkg::*;
	localparam int sec = 10;
	localparam logic [31:0] pid = 32'h41424344; // arbitrary value
	localparam logic [15:0] base = 16'h0100;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] out_word0_i = 16'h0000;
	logic [15:0] out_word_i [1:6];
	logic [15:0] status_addr_i = 16'hffff;
	logic [15:0] status_freq_i = 16'h0000;
	logic [15:0] cmd_delay_i = 16'h0000;
	logic [6:0] cmd_count_i = 7'h00;
	logic [6:0] cfg_index_i = 7'h00;
	logic cfg_we_i = 1'b0;
	logic [15:0] cfg_poll_i = 16'h0000;
	logic [1:0] cfg_enable_i = 2'h0;
	logic cfg_write_i = 1'b0;
	logic [15:0] cfg_data_i = 16'h0000;
	logic issue_done_i;
	logic [15:0] in_word0_o;
	logic [15:0] in_word2_o;
	logic issue_valid_o;
	issue_type issue_o;
	db_write_type db_o;
	logic reload_o;
	logic restart_o;
	logic [7:0] latency = 8'h00;
	logic [15:0] stat [0:31];
	logic [15:0] off;
	int bad_count = 0;
	int tests_run = 0;
	int db_n, bad_addr, n_reload, n_restart, n_ack;

	// 125 MHz
	always #4 clk_i = ~clk_i;

	block_transfer_command_scheduler #(.sec_cycles(sec), .product_id(pid)) u_block_transfer_command_scheduler (
		.clk_i(clk_i), .rst_i(rst_i), .out_word0_i(out_word0_i), .out_word_i(out_word_i),
		.status_addr_i(status_addr_i), .status_freq_i(status_freq_i), .cmd_delay_i(cmd_delay_i),
		.cmd_count_i(cmd_count_i), .cfg_index_i(cfg_index_i), .cfg_we_i(cfg_we_i), .cfg_poll_i(cfg_poll_i),
		.cfg_enable_i(cfg_enable_i), .cfg_write_i(cfg_write_i), .cfg_data_i(cfg_data_i),
		.issue_done_i(issue_done_i), .in_word0_o(in_word0_o), .in_word2_o(in_word2_o),
		.issue_valid_o(issue_valid_o), .issue_o(issue_o), .db_o(db_o), .reload_o(reload_o),
		.restart_o(restart_o));

	port_model u_port_model (.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid_o), .issue_i(issue_o),
		.latency_i(latency), .done_o(issue_done_i));

	// watch database writes and the boot pulses, sampled before the edge lands
	always @(posedge clk_i) begin
		if (db_o.valid === 1'b1) begin
			db_n++;
			off = db_o.addr - base;
			if (off > 16'h001f) bad_addr++;
			else stat[off[4:0]] = db_o.data;
		end
		if (reload_o === 1'b1) n_reload++;
		if (restart_o === 1'b1) n_restart++;
		if (in_word0_o === warm_start_code || in_word0_o === restart_code) n_ack++;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task close_out;
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	task do_reset;
		out_word0_i = 16'h0000; // a stale code would be taken as new after release
		rst_i = 1'b1;
		cyc(2);
		rst_i = 1'b0;
		cyc(2);
	endtask : do_reset

	// bounded wait for the port log to reach n entries
	task wait_log(input int n);
		for (int i = 0; i < 3000 && u_port_model.log_idx.size() < n; i++) cyc(1);
		if (u_port_model.log_idx.size() < n) begin
			chk(u_port_model.log_idx.size(), n);
			close_out();
		end
	endtask : wait_log

	task wait_db(input int n);
		for (int i = 0; i < 3000 && db_n < n; i++) cyc(1);
		if (db_n < n) begin
			chk(db_n, n);
			close_out();
		end
	endtask : wait_db

	task cfg(input int idx, input logic [15:0] poll, input logic [1:0] en, input logic [15:0] d);
		cfg_index_i = idx[6:0];
		cfg_poll_i = poll;
		cfg_enable_i = en;
		cfg_write_i = 1'b1;
		cfg_data_i = d;
		cfg_we_i = 1'b1;
		cyc(1);
		cfg_we_i = 1'b0;
		cyc(1);
	endtask : cfg

	task queue_block(input int k);
		for (int j = 1; j <= 6; j++) out_word_i[j] = 16'(6 - j);
		out_word0_i = queue_code_base + 16'(k);
	endtask : queue_block

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_queue_codes;
		int n0;
		latency = 8'h03;
		for (int k = 1; k <= 6; k++) begin
			n0 = u_port_model.log_idx.size();
			queue_block(k);
			cyc(6);
			chk(in_word0_o, 32'(queue_code_base) + k);
			chk(in_word2_o, k);
			wait_log(n0 + k);
			cyc(10);
			chk(u_port_model.log_idx.size(), n0 + k);
			for (int j = 0; j < k; j++) chk(u_port_model.log_idx[n0 + j], 5 - j);
		end
	endtask : t_queue_codes

	// slow port holds the fifo: second block only fits three indexes
	task t_refuse;
		int n0;
		n0 = u_port_model.log_idx.size();
		latency = 8'hc8;
		out_word0_i = 16'h0000; // repeating the last code would not be seen as new
		cyc(4);
		queue_block(6);
		wait_log(n0 + 1);
		cyc(10);
		queue_block(5);
		cyc(6);
		chk(in_word2_o, 3);
		latency = 8'h00;
		wait_log(n0 + 9);
		cyc(20);
		chk(u_port_model.log_idx.size(), n0 + 9);
	endtask : t_refuse

	task t_list;
		do_reset();
		cmd_delay_i = 16'h0001;
		cfg(0, 16'h0002, 2'h1, 16'h0011);
		cfg(1, 16'h0002, 2'h1, 16'h0022);
		cfg(99, 16'h0002, 2'h1, 16'h0033);
		cmd_count_i = 7'd100;
		wait_log(4);
		chk(u_port_model.log_idx[0], 0);
		chk(u_port_model.log_idx[1], 1);
		chk(u_port_model.log_idx[2], 99);
		chk(u_port_model.log_idx[3], 0);
		chk(u_port_model.log_cyc[1] - u_port_model.log_cyc[0] >= sec, 1);
		chk(u_port_model.log_cyc[3] - u_port_model.log_cyc[0] >= 2 * sec, 1);
		cmd_count_i = 7'd0;
		cmd_delay_i = 16'h0000;
	endtask : t_list

	task t_change;
		do_reset();
		cfg(0, 16'h0000, 2'h2, 16'h1234);
		cmd_count_i = 7'd1;
		wait_log(1);
		chk(u_port_model.log_dat[0], 16'h1234);
		cyc(200);
		chk(u_port_model.log_idx.size(), 1);
		cfg(0, 16'h0000, 2'h2, 16'h1235);
		wait_log(2);
		chk(u_port_model.log_dat[1], 16'h1235);
		cmd_count_i = 7'd0;
	endtask : t_change

	task t_status;
		do_reset();
		db_n = 0;
		bad_addr = 0;
		status_addr_i = 16'hffff;
		status_freq_i = 16'h0004;
		cyc(100);
		status_addr_i = base;
		status_freq_i = 16'h0000;
		cyc(100);
		chk(db_n, 0);
		status_freq_i = 16'h00c8;
		wait_db(32);
		cyc(5);
		chk(db_n, 32);
		chk(bad_addr, 0);
		chk(stat[9], pid[31:16]);
		chk(stat[10], pid[15:0]);
		chk(stat[24], 0);
	endtask : t_status

	task t_boot;
		status_freq_i = 16'h0004;
		queue_block(1);
		cyc(40);
		db_n = 0;
		wait_db(64);
		chk(stat[30] != 16'h0000, 1);
		n_reload = 0;
		n_restart = 0;
		n_ack = 0;
		out_word0_i = warm_start_code;
		cyc(10);
		chk(n_reload, 1);
		chk(n_restart, 0);
		db_n = 0;
		wait_db(32);
		chk(stat[30], 0);
		out_word0_i = restart_code;
		cyc(10);
		chk(n_restart, 1);
		chk(n_ack, 0);
	endtask : t_boot

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		for (int j = 1; j <= 6; j++) out_word_i[j] = 16'h0000;
		db_n = 0;
		bad_addr = 0;
		n_reload = 0;
		n_restart = 0;
		n_ack = 0;
		cyc(2);
		rst_i = 1'b0;
		cyc(1);
		chk(in_word2_o, 0);
		chk(issue_valid_o, 0);
		cyc(2);
		t_queue_codes();
		t_refuse();
		t_list();
		t_change();
		t_status();
		t_boot();
		close_out();
	end
endmodule : tb
